// *** common/rcdr_map.vh ***
// Constant map of the receive lock controller and deserializer.
// Assumes inclusion by bare name from every design file of the block.
`ifndef RCDR_MAP_VH
`define RCDR_MAP_VH

// Register byte offsets
`define RCDR_CTRL_OFS 12'h000
`define RCDR_STAT_OFS 12'h004
`define RCDR_PPM_OFS 12'h008
`define RCDR_WORD_OFS 12'h00c

// Control register fields
`define RCDR_CTRL_MAN_BIT 0
`define RCDR_CTRL_LTR_BIT 1
`define RCDR_CTRL_LTD_BIT 2
`define RCDR_CTRL_PIPE_BIT 3
`define RCDR_CTRL_CODER_BIT 4
`define RCDR_CTRL_W10_BIT 5
`define RCDR_CTRL_PLLSEL_BIT 6
`define RCDR_CTRL_W 7
`define RCDR_CTRL_RST 7'h00

// Status register fields
`define RCDR_STAT_LOCK_BIT 0
`define RCDR_STAT_SIGDET_BIT 1
`define RCDR_STAT_DATA_BIT 2
`define RCDR_STAT_WVALID_BIT 3

// Ppm threshold, in frequency counts per window
`define RCDR_PPM_W 16
`define RCDR_PPM_RST 16'h0004
`define RCDR_WIN_W 16
`define RCDR_WIN_LEN 16'h1000

// Lock states
`define RCDR_ST_REF 1'b0
`define RCDR_ST_DATA 1'b1

// Signal detect hysteresis levels, 4-bit level code
`define RCDR_SD_ON 4'h9
`define RCDR_SD_OFF 4'h5

// Deserializer
`define RCDR_WORD_W 10
`define RCDR_CNT_W 4
`define RCDR_CNT_8 4'h8
`define RCDR_CNT_10 4'ha

`endif

// *** rtl/rcdr_sigdet.v ***
// Signal detect qualifier with hysteresis.
// Assumes a level code from the input buffer already on core_clk.
`timescale 1ns/1ps
module rcdr_sigdet (
    core_clk,
    reset,
    level,
    coder_en,
    sig_detect
);
`include "rcdr_map.vh"
    input wire core_clk;
    input wire reset;
    input wire [3:0] level;
    input wire coder_en;
    output wire sig_detect;

    reg det_q;
    reg det_d;

    // Rise at or above the on level, fall only at or below the off level
    always @* begin
        det_d = det_q;
        if (level >= `RCDR_SD_ON) begin
            det_d = 1'b1;
        end else if (level <= `RCDR_SD_OFF) begin
            det_d = 1'b0;
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            det_q <= 1'b0;
        end else begin
            det_q <= det_d;
        end
    end

    // Forced high when the coder is off
    assign sig_detect = coder_en ? det_q : 1'b1;
endmodule

// *** rtl/rcdr_deser.v ***
// Deserializer: two bits per high speed clock, LSB first, 8 or 10 bit words.
// Assumes hs_clk runs at half the bit rate from the recovery unit.
`timescale 1ns/1ps
module rcdr_deser (
    hs_clk,
    reset,
    ser_in,
    width10,
    word_out,
    word_tgl
);
`include "rcdr_map.vh"
    input wire hs_clk;
    input wire reset;
    input wire ser_in;
    input wire width10;
    output reg [`RCDR_WORD_W-1:0] word_out;
    output reg word_tgl;

    reg bit_rise_q;
    reg [`RCDR_WORD_W-1:0] sh_q;
    reg [`RCDR_CNT_W-1:0] cnt_q;
    wire [`RCDR_CNT_W-1:0] lim;
    wire [`RCDR_WORD_W-1:0] sh_d;

    // Earlier bit of each pair, taken on the rising edge
    always @(posedge hs_clk or posedge reset) begin
        if (reset) begin
            bit_rise_q <= 1'b0;
        end else begin
            bit_rise_q <= ser_in;
        end
    end

    // Later bit joins on the falling edge; each pair enters at the top, earlier bit lower
    assign lim = width10 ? `RCDR_CNT_10 : `RCDR_CNT_8;
    assign sh_d = {ser_in, bit_rise_q, sh_q[`RCDR_WORD_W-1:2]};

    // Shift and word completion on the falling edge, so a frame that parks the clock low
    // still delivers its last word
    always @(negedge hs_clk or posedge reset) begin
        if (reset) begin
            sh_q <= {`RCDR_WORD_W{1'b0}};
            cnt_q <= {`RCDR_CNT_W{1'b0}};
            word_out <= {`RCDR_WORD_W{1'b0}};
            word_tgl <= 1'b0;
        end else begin
            sh_q <= sh_d;
            if (cnt_q + 4'h2 >= lim) begin
                cnt_q <= {`RCDR_CNT_W{1'b0}};
                word_out <= width10 ? sh_d : {2'b00, sh_d[`RCDR_WORD_W-1:2]};
                word_tgl <= ~word_tgl;
            end else begin
                cnt_q <= cnt_q + 4'h2;
            end
        end
    end
endmodule

// *** rtl/rcdr_top.v ***
// Receive front end: signal detect, lock controller, deserializer, APB slave.
// Assumes an APB master on core_clk; serial bits and recovered clocks from the link.
`timescale 1ns/1ps
// Function
// - Channel has its own recovery unit deriving a clock from serial data.
// - Low speed recovered clock drives coding blocks, high speed drives deserializer.
// - Reference lock state disables phase detector and ignores data.
// - Data lock state enables phase detector and tracks incoming data.
// - Reset places the recovery unit in reference lock.
// - Automatic: go to data lock when within ppm; PIPE also needs signal.
// - Automatic: return to reference lock outside ppm; PIPE also on signal loss.
// - Outside PIPE mode, signal detect is ignored for transitions.
// - Automatic: locked output follows switches into and out of data lock.
// - Manual: state set only by the two lock select levels from fabric.
// - Manual: locked output high in data lock, low in reference lock.
// - With lock selects not enabled, controller runs automatically.
// - Signal detect asserts above threshold, with hysteresis against ringing.
// - Signal detect only with coder enabled, else held high.
// - Deserializer builds 8 or 10 bit words by configuration.
// - First received bit lands at LSB; far end sends LSB first.
// - Deserializer clocked at half bit rate, capturing on both edges.
// - Reference clock comes from one of two PLLs, chosen by configuration.
// - Parallel output feeds the word aligner.
module rcdr_top (
    core_clk,
    reset,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    pll0_clk,
    pll1_clk,
    rec_clk_hs,
    rec_clk_ls,
    ser_in,
    sig_level,
    lock_to_ref,
    lock_to_data,
    freq_locked,
    sig_detect,
    phase_det_en,
    ref_clk_sel,
    align_data,
    align_valid
);
`include "rcdr_map.vh"
    input wire core_clk;
    input wire reset;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire pll0_clk;
    input wire pll1_clk;
    input wire rec_clk_hs;
    input wire rec_clk_ls;
    input wire ser_in;
    input wire [3:0] sig_level;
    input wire lock_to_ref;
    input wire lock_to_data;
    output reg freq_locked;
    output wire sig_detect;
    output reg phase_det_en;
    output reg ref_clk_sel;
    output reg [`RCDR_WORD_W-1:0] align_data;
    output reg align_valid;

    reg [`RCDR_CTRL_W-1:0] ctrl_q;
    reg [`RCDR_PPM_W-1:0] ppm_q;
    reg state_q;
    reg state_d;
    reg [1:0] ltr_s_q;
    reg [1:0] ltd_s_q;
    reg [3:0] lvl1_q;
    reg [3:0] lvl2_q;
    reg [`RCDR_WIN_W-1:0] win_q;
    reg [`RCDR_WIN_W-1:0] cnt_ref_q;
    reg [`RCDR_WIN_W-1:0] cnt_rec_q;
    reg in_ppm_q;
    reg rtog_q;
    reg [2:0] rtog_s_q;
    reg ptog_q;
    reg [2:0] ptog_s_q;
    reg ptog1_q;
    reg [2:0] wtog_s_q;
    reg [`RCDR_WORD_W-1:0] word_q;
    reg word_valid_q;
    wire [`RCDR_WORD_W-1:0] des_word;
    wire des_tgl;
    wire manual;
    wire wr_en;
    wire rd_en;
    wire sdet;
    wire [`RCDR_WIN_W-1:0] diff;

    // Select decode, shared by read and write
    function sel_hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            sel_hit = (a == ofs);
        end
    endfunction

    // APB: zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;
    assign pslverr = psel & penable & ~(sel_hit(paddr, `RCDR_CTRL_OFS) |
        sel_hit(paddr, `RCDR_STAT_OFS) | sel_hit(paddr, `RCDR_PPM_OFS) |
        sel_hit(paddr, `RCDR_WORD_OFS));

    // Configuration registers
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `RCDR_CTRL_RST;
            ppm_q <= `RCDR_PPM_RST;
        end else if (wr_en) begin
            if (sel_hit(paddr, `RCDR_CTRL_OFS)) begin
                ctrl_q <= pwdata[`RCDR_CTRL_W-1:0];
            end
            if (sel_hit(paddr, `RCDR_PPM_OFS)) begin
                ppm_q <= pwdata[`RCDR_PPM_W-1:0];
            end
        end
    end

    // Read data registered in setup phase
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_en && !penable) begin
            prdata <= 32'h00000000;
            if (sel_hit(paddr, `RCDR_CTRL_OFS)) begin
                prdata[`RCDR_CTRL_W-1:0] <= ctrl_q;
            end
            if (sel_hit(paddr, `RCDR_STAT_OFS)) begin
                prdata[`RCDR_STAT_LOCK_BIT] <= freq_locked;
                prdata[`RCDR_STAT_SIGDET_BIT] <= sdet;
                prdata[`RCDR_STAT_DATA_BIT] <= state_q;
                prdata[`RCDR_STAT_WVALID_BIT] <= word_valid_q;
            end
            if (sel_hit(paddr, `RCDR_PPM_OFS)) begin
                prdata[`RCDR_PPM_W-1:0] <= ppm_q;
            end
            if (sel_hit(paddr, `RCDR_WORD_OFS)) begin
                prdata[`RCDR_WORD_W-1:0] <= word_q;
            end
        end
    end

    // Pin synchronisers for lock selects and signal level
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ltr_s_q <= 2'b00;
            ltd_s_q <= 2'b00;
            lvl1_q <= 4'h0;
            lvl2_q <= 4'h0;
        end else begin
            ltr_s_q <= {ltr_s_q[0], lock_to_ref};
            ltd_s_q <= {ltd_s_q[0], lock_to_data};
            lvl1_q <= sig_level;
            lvl2_q <= lvl1_q;
        end
    end

    rcdr_sigdet u_sigdet (
        .core_clk(core_clk),
        .reset(reset),
        .level(lvl2_q),
        .coder_en(ctrl_q[`RCDR_CTRL_CODER_BIT]),
        .sig_detect(sdet)
    );
    assign sig_detect = sdet;

    // Toggle counters on the first PLL clock and the recovered clock
    always @(posedge pll0_clk or posedge reset) begin
        if (reset) begin
            ptog_q <= 1'b0;
        end else begin
            ptog_q <= ~ptog_q;
        end
    end

    // Same toggle on the second PLL, so either source is metered at the same scale
    always @(posedge pll1_clk or posedge reset) begin
        if (reset) begin
            ptog1_q <= 1'b0;
        end else begin
            ptog1_q <= ~ptog1_q;
        end
    end

    always @(posedge rec_clk_ls or posedge reset) begin
        if (reset) begin
            rtog_q <= 1'b0;
        end else begin
            rtog_q <= ~rtog_q;
        end
    end

    // Reference source choice; it also steers which PLL toggle the ppm meter counts
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ref_clk_sel <= 1'b0;
        end else begin
            ref_clk_sel <= ctrl_q[`RCDR_CTRL_PLLSEL_BIT];
        end
    end

    // Synchronise toggles, count edges per window, compare
    assign diff = (cnt_ref_q > cnt_rec_q) ? cnt_ref_q - cnt_rec_q : cnt_rec_q - cnt_ref_q;
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ptog_s_q <= 3'b000;
            rtog_s_q <= 3'b000;
            win_q <= {`RCDR_WIN_W{1'b0}};
            cnt_ref_q <= {`RCDR_WIN_W{1'b0}};
            cnt_rec_q <= {`RCDR_WIN_W{1'b0}};
            in_ppm_q <= 1'b0;
        end else begin
            ptog_s_q <= {ptog_s_q[1:0], ref_clk_sel ? ptog1_q : ptog_q};
            rtog_s_q <= {rtog_s_q[1:0], rtog_q};
            if (win_q == `RCDR_WIN_LEN) begin
                win_q <= {`RCDR_WIN_W{1'b0}};
                in_ppm_q <= (diff <= ppm_q);
                cnt_ref_q <= {`RCDR_WIN_W{1'b0}};
                cnt_rec_q <= {`RCDR_WIN_W{1'b0}};
            end else begin
                win_q <= win_q + 16'h0001;
                cnt_ref_q <= cnt_ref_q + {15'h0000, ptog_s_q[2] ^ ptog_s_q[1]};
                cnt_rec_q <= cnt_rec_q + {15'h0000, rtog_s_q[2] ^ rtog_s_q[1]};
            end
        end
    end

    // Manual when configured and a select is asserted
    assign manual = ctrl_q[`RCDR_CTRL_MAN_BIT] & (ltr_s_q[1] | ltd_s_q[1]);

    // Lock state decision
    always @* begin
        state_d = state_q;
        if (manual) begin
            if (ltr_s_q[1]) begin
                state_d = `RCDR_ST_REF;
            end else begin
                state_d = `RCDR_ST_DATA;
            end
        end else begin
            case (state_q)
                `RCDR_ST_REF: begin
                    if (in_ppm_q && (!ctrl_q[`RCDR_CTRL_PIPE_BIT] || sdet)) begin
                        state_d = `RCDR_ST_DATA;
                    end
                end
                `RCDR_ST_DATA: begin
                    if (!in_ppm_q || (ctrl_q[`RCDR_CTRL_PIPE_BIT] && !sdet)) begin
                        state_d = `RCDR_ST_REF;
                    end
                end
                default: begin
                    state_d = `RCDR_ST_REF;
                end
            endcase
        end
    end

    // Registered state and lock outputs
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= `RCDR_ST_REF;
            freq_locked <= 1'b0;
            phase_det_en <= 1'b0;
        end else begin
            state_q <= state_d;
            freq_locked <= (state_d == `RCDR_ST_DATA);
            phase_det_en <= (state_d == `RCDR_ST_DATA);
        end
    end

    rcdr_deser u_deser (
        .hs_clk(rec_clk_hs),
        .reset(reset),
        .ser_in(ser_in),
        .width10(ctrl_q[`RCDR_CTRL_W10_BIT]),
        .word_out(des_word),
        .word_tgl(des_tgl)
    );

    // Word hand-off to the aligner side, gated by data lock; the word toggle is
    // synchronised and the word itself stands for several cycles after it flips
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wtog_s_q <= 3'b000;
            word_q <= {`RCDR_WORD_W{1'b0}};
            word_valid_q <= 1'b0;
            align_data <= {`RCDR_WORD_W{1'b0}};
            align_valid <= 1'b0;
        end else begin
            wtog_s_q <= {wtog_s_q[1:0], des_tgl};
            align_valid <= 1'b0;
            if ((wtog_s_q[2] ^ wtog_s_q[1]) && state_q == `RCDR_ST_DATA) begin
                word_q <= des_word;
                word_valid_q <= 1'b1;
                align_data <= des_word;
                align_valid <= 1'b1;
            end
        end
    end
endmodule

// *** testbench/rcdr_checker.sv ***
// Port assertions for the receive lock controller and deserializer.
// Assumes binding to rcdr_top; control bits are shadowed from APB writes.
`timescale 1ns/1ps
`include "rcdr_map.vh"
module rcdr_checker (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] sig_level,
    input wire lock_to_ref,
    input wire lock_to_data,
    input wire freq_locked,
    input wire sig_detect,
    input wire phase_det_en,
    input wire ref_clk_sel,
    input wire align_valid
);
    reg [6:0] ctrl_q;
    // Shadow of the control register
    always @(posedge core_clk or posedge reset) begin
        if (reset)
            ctrl_q <= 7'h00;
        else if (psel && penable && pwrite && paddr == `RCDR_CTRL_OFS)
            ctrl_q <= pwdata[6:0];
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    reset_ref_a: assert property ($fell(reset) |-> !freq_locked && !phase_det_en)
        else $error("lock state not cleared by reset");
    lock_follow_a: assert property ($changed(phase_det_en) |-> ##[0:2] (freq_locked == phase_det_en))
        else $error("locked output does not follow the state");
    man_ref_a: assert property ((ctrl_q[0] && lock_to_ref)[*7] |-> !freq_locked && !phase_det_en)
        else $error("manual reference select ignored");
    man_data_a: assert property ((ctrl_q[0] && lock_to_data && !lock_to_ref)[*7] |-> freq_locked && phase_det_en)
        else $error("manual data select ignored");
    pipe_loss_a: assert property ((!ctrl_q[0] && ctrl_q[3] && ctrl_q[4] && !sig_detect)[*6] |-> !freq_locked)
        else $error("lock held without signal in PIPE mode");
    sd_bypass_a: assert property ((!ctrl_q[4])[*2] |-> sig_detect)
        else $error("signal detect not forced with coder off");
    sd_on_a: assert property ((ctrl_q[4] && sig_level >= 4'h9)[*4] |-> sig_detect)
        else $error("signal detect low above threshold");
    sd_hold_a: assert property ((ctrl_q[4] && sig_level > 4'h5 && sig_level < 4'h9)[*4] |-> $stable(sig_detect))
        else $error("signal detect moved inside hysteresis band");
    sel_copy_a: assert property ($stable(ctrl_q)[*2] |-> ref_clk_sel == ctrl_q[6])
        else $error("reference clock select differs from control");
    word_pulse_a: assert property (align_valid |=> !align_valid)
        else $error("word strobe longer than one cycle");
endmodule

// *** testbench/rcdr_tx_model.sv ***
// Far end serial transmitter: half rate clock, one bit on each edge.
// Assumes the receiver captures on both edges of rec_clk_hs.
`timescale 1ns/1ps
module rcdr_tx_model (
    output logic rec_clk_hs,
    output logic ser_in
);
    initial begin
        rec_clk_hs = 1'b0;
        ser_in = 1'b1;
    end
    // Sends one word LSB first; clock stands low between frames
    task send_word(input logic [9:0] w, input int n);
        for (int i = 0; i < n; i += 2) begin
            ser_in = w[i];
            #25 rec_clk_hs = 1'b1;
            #25 ser_in = w[i+1];
            #25 rec_clk_hs = 1'b0;
            #25;
        end
        ser_in = ~ser_in; // Released line shows no stale bit
    endtask
endmodule

// *** testbench/rx_cdr_lock_and_deserializer_bench.sv ***
// Self-checking bench of the receive lock controller and deserializer.
// Assumes rcdr_top with its map header; APB master and slow clocks are local.
`timescale 1ns/1ps
`include "rcdr_map.vh"
`define RCHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module rx_cdr_lock_and_deserializer_bench;
    typedef struct {
        logic [6:0] ctrl;
        logic lref;
        logic ldata;
        logic [3:0] lvl;
        logic lock;
        logic sd;
    } rcdr_row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, freq_locked, sig_detect, phase_det_en, ref_clk_sel, align_valid, err;
    logic pll_clk = 1'b0, rec_clk_ls = 1'b0, ls_run = 1'b0;
    logic [3:0] sig_level = 4'h0;
    logic lock_to_ref = 1'b0, lock_to_data = 1'b0;
    logic [9:0] align_data;
    logic [1:0] div_q = 2'h0;
    wire rec_clk_hs, ser_in;
    logic [9:0] got_q[$];
    int errors = 0, num_checks = 0;
    rcdr_row_t rows[8] = '{
        '{7'h01, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1},
        '{7'h11, 1'b0, 1'b1, 4'h9, 1'b1, 1'b1},
        '{7'h11, 1'b1, 1'b1, 4'h7, 1'b0, 1'b1},
        '{7'h11, 1'b0, 1'b1, 4'h5, 1'b1, 1'b0},
        '{7'h11, 1'b0, 1'b1, 4'h8, 1'b1, 1'b0},
        '{7'h11, 1'b1, 1'b0, 4'h8, 1'b0, 1'b0},
        '{7'h10, 1'b0, 1'b1, 4'hf, 1'b0, 1'b1},
        '{7'h00, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1}
    };
    rcdr_top i_dut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll0_clk(pll_clk), .pll1_clk(pll_clk), .rec_clk_hs(rec_clk_hs), .rec_clk_ls(rec_clk_ls),
        .ser_in(ser_in), .sig_level(sig_level), .lock_to_ref(lock_to_ref),
        .lock_to_data(lock_to_data), .freq_locked(freq_locked), .sig_detect(sig_detect),
        .phase_det_en(phase_det_en), .ref_clk_sel(ref_clk_sel), .align_data(align_data),
        .align_valid(align_valid)
    );
    rcdr_tx_model i_tx (.rec_clk_hs(rec_clk_hs), .ser_in(ser_in));
    // Core clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Reference and recovered slow clocks, eight core cycles a period
    always @(posedge core_clk) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            pll_clk <= ~pll_clk;
            if (ls_run) rec_clk_ls <= ~rec_clk_ls;
        end
    end
    // Collects forwarded words
    always @(posedge core_clk) begin
        if (align_valid === 1'b1) got_q.push_back(align_data);
    end
    task report_and_stop;
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 16) begin
            errors++;
            report_and_stop;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task wait_lock(input logic v);
        int n;
        n = 0;
        while (freq_locked !== v && n < 14000) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 14000) begin
            errors++;
            report_and_stop;
        end
        `RCHK(freq_locked, v)
    endtask
    task do_reset(input int n);
        reset <= 1'b1;
        repeat (n) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
    endtask
    // Main sequence
    initial begin
        do_reset(12);
        foreach (rows[i]) begin
            lock_to_ref <= rows[i].lref;
            lock_to_data <= rows[i].ldata;
            sig_level <= rows[i].lvl;
            apb(`RCDR_CTRL_OFS, 1'b1, {25'h0, rows[i].ctrl});
            repeat (8) @(posedge core_clk);
            `RCHK(freq_locked, rows[i].lock)
            `RCHK(phase_det_en, rows[i].lock)
            `RCHK(sig_detect, rows[i].sd)
            apb(`RCDR_STAT_OFS, 1'b0, 32'h0);
            `RCHK(rd[2:0], ({rows[i].lock, rows[i].sd, rows[i].lock}))
        end
        lock_to_data <= 1'b1;
        apb(`RCDR_CTRL_OFS, 1'b1, 32'h41);
        repeat (8) @(posedge core_clk);
        `RCHK(ref_clk_sel, 1'b1)
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        `RCHK(({freq_locked, phase_det_en, sig_detect, pready}), 4'h3)
        reset <= 1'b0;
        @(posedge core_clk);
        apb(`RCDR_PPM_OFS, 1'b0, 32'h0);
        `RCHK(rd, 32'h4)
        `RCHK(ref_clk_sel, 1'b0)
        apb(12'h010, 1'b0, 32'h0);
        `RCHK(({err, rd}), 33'h100000000)
        // Ten bit words, back to back
        apb(`RCDR_CTRL_OFS, 1'b1, 32'h31);
        repeat (8) @(posedge core_clk);
        i_tx.send_word(10'h2a5, 10);
        i_tx.send_word(10'h0f3, 10);
        i_tx.send_word(10'h3c1, 10);
        repeat (20) @(posedge core_clk);
        `RCHK(got_q.size(), 3)
        `RCHK(({got_q[0], got_q[1], got_q[2]}), ({10'h2a5, 10'h0f3, 10'h3c1}))
        apb(`RCDR_WORD_OFS, 1'b0, 32'h0);
        `RCHK(rd, 32'h3c1)
        // Eight bit words, then one sent in reference lock
        got_q.delete();
        do_reset(2);
        apb(`RCDR_CTRL_OFS, 1'b1, 32'h01);
        repeat (8) @(posedge core_clk);
        i_tx.send_word(10'h0a5, 8);
        i_tx.send_word(10'h03c, 8);
        @(posedge core_clk);
        lock_to_ref <= 1'b1;
        repeat (8) @(posedge core_clk);
        i_tx.send_word(10'h077, 8);
        repeat (20) @(posedge core_clk);
        `RCHK(got_q.size(), 2)
        `RCHK(({got_q[0], got_q[1]}), ({10'h0a5, 10'h03c}))
        // Automatic lock against the reference
        do_reset(2);
        ls_run <= 1'b1;
        lock_to_ref <= 1'b0;
        lock_to_data <= 1'b0;
        apb(`RCDR_CTRL_OFS, 1'b1, 32'h10);
        wait_lock(1'b1);
        `RCHK(sig_detect, 1'b0)
        apb(`RCDR_CTRL_OFS, 1'b1, 32'h18);
        wait_lock(1'b0);
        sig_level <= 4'hf;
        wait_lock(1'b1);
        ls_run <= 1'b0;
        wait_lock(1'b0);
        report_and_stop;
    end
endmodule
bind rcdr_top rcdr_checker i_chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .sig_level(sig_level), .lock_to_ref(lock_to_ref),
    .lock_to_data(lock_to_data), .freq_locked(freq_locked), .sig_detect(sig_detect),
    .phase_det_en(phase_det_en), .ref_clk_sel(ref_clk_sel), .align_valid(align_valid)
);
